// ==== bench/adc_analog_model.sv ====
// Behavioural analog core: source levels, input switch and comparator.
// Assumes a one-hot switch select and a 12-bit trial code.
`timescale 1ns/1ps
module adc_analog_model (
  input  wire logic        i_core_clk,
  input  wire logic        i_power,
  input  wire logic [11:0] i_dac,
  input  wire logic [13:0] i_sel,
  output logic             o_cmp
);
  logic [11:0] lvl [14];
  logic        noise = 1'b0;
  // An open or unpowered input gives no steady answer, so a slip shows.
  always @(posedge i_core_clk) noise <= ~noise;
  always_comb begin
    o_cmp = noise;
    for (int k = 0; k < 14; k++) begin
      if (i_power && i_sel == 14'h0001 << k) o_cmp = lvl[k] >= i_dac;
    end
  end
endmodule // adc_analog_model

// ==== bench/adc_conversion_control_asserts.sv ====
// Port checker for the converter control, bound to the top module.
// Assumes one core clock and an asynchronous active-high reset.
`timescale 1ns/1ps
module adc_conversion_control_chk (
  input wire logic        i_core_clk,
  input wire logic        i_rst,
  input wire logic [7:0]  i_addr,
  input wire logic [7:0]  i_wdata,
  input wire logic        i_wr,
  input wire logic        i_rd,
  input wire logic [7:0]  o_rdata,
  input wire logic        o_adc_power,
  input wire logic        o_sample,
  input wire logic [13:0] o_in_sel,
  input wire logic        o_irq
);
  wire logic       mw = i_wr && i_addr == adc_ctrl_pkg::OFS_MODE;
  wire logic [3:0] ch = i_wdata[3:0];
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (i_rst);
  chk_start_zero: assert property (
    $past(i_rd) && $past(i_addr) == 8'h10 |-> !o_rdata[6]) else $error("start reads one");
  chk_power_follow: assert property (
    mw |=> o_adc_power == $past(i_wdata[7])) else $error("power wrong");
  chk_gate_open: assert property (
    mw && !i_wdata[4] |-> ##2 o_in_sel == 14'h0000) else $error("inputs not open");
  chk_pad_select: assert property (
    mw && i_wdata[4] && ch < 4'hc |-> ##2 o_in_sel == 14'h0001 << $past(ch, 2))
    else $error("pad select wrong");
  chk_ref_select: assert property (
    mw && i_wdata[4] && ch[3:1] == 3'h6 |-> ##2
    o_in_sel == ($past(ch[0], 2) ? 14'h2000 : 14'h1000)) else $error("reference wrong");
  // The flag only drops by software, so a quiet bus must keep the request.
  chk_irq_sticky: assert property (
    o_irq && !i_wr && !$past(i_wr) |=> o_irq) else $error("irq dropped");
  chk_sample_power: assert property (
    $rose(o_sample) |-> o_adc_power) else $error("sample while off");
  chk_irq_late: assert property (
    $rose(o_irq) && !$past(i_wr) |-> !$past(o_sample)) else $error("irq in sampling");
endmodule // adc_conversion_control_chk
bind adc_conversion_control adc_conversion_control_chk adc_conversion_control_chk_i (
  .i_core_clk(i_core_clk), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata),
  .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_adc_power(o_adc_power),
  .o_sample(o_sample), .o_in_sel(o_in_sel), .o_irq(o_irq));

// ==== bench/adc_conversion_control_test.sv ====
// Bench for the converter control: registers, conversions and interrupts.
// Assumes the analog model answers the comparator from the selected level.
`timescale 1ns/1ps
module adc_conversion_control_test;
  logic        i_core_clk = 1'b0;
  logic        i_rst      = 1'b1;
  logic [7:0]  i_addr     = 8'h00;
  logic [7:0]  i_wdata    = 8'h00;
  logic        i_wr       = 1'b0;
  logic        i_rd       = 1'b0;
  logic        i_cmp, o_adc_power, o_sample, o_irq;
  logic [7:0]  o_rdata;
  logic [11:0] o_dac;
  logic [13:0] o_in_sel, rv;
  int          mismatches = 0;
  int          cmp_count  = 0;
  int          t;
  always #2.5 i_core_clk = ~i_core_clk;
  adc_conversion_control adc_conversion_control_i (.i_core_clk(i_core_clk), .i_rst(i_rst),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .i_cmp(i_cmp),
    .o_rdata(o_rdata), .o_adc_power(o_adc_power), .o_sample(o_sample), .o_dac(o_dac),
    .o_in_sel(o_in_sel), .o_irq(o_irq));
  adc_analog_model adc_analog_model_i (.i_core_clk(i_core_clk), .i_power(o_adc_power),
    .i_dac(o_dac), .i_sel(o_in_sel), .o_cmp(i_cmp));
  task automatic final_report();
    $display("Checks %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input string n, input logic [13:0] e, g);
    cmp_count++;
    if (g !== e) begin
      mismatches++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, d);
    @(posedge i_core_clk);
    i_addr  <= a;
    i_wdata <= d;
    i_wr    <= 1'b1;
    @(posedge i_core_clk);
    i_wr    <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge i_core_clk);
    i_addr <= a;
    i_rd   <= 1'b1;
    @(posedge i_core_clk);
    i_rd   <= 1'b0;
    #1 rv = {6'h00, o_rdata};
  endtask
  task automatic wait_irq();
    for (t = 0; o_irq !== 1'b1 && t < 2000; t++) begin
      @(posedge i_core_clk);
      #1;
    end
    if (t >= 2000) begin
      mismatches++;
      final_report();
    end
  endtask
  // Expected duration allows one tick of slack for the divider phase.
  task automatic conv(input int ch, d, r);
    int n, dv, e, s;
    logic [11:0] x;
    s  = $urandom % 4;
    n  = r > 1 ? 12 : 8 + 2 * r;
    dv = d == 2 ? 1 : d == 3 ? 2 : 16 >> d;
    e  = ((1 << s) + n) * dv;
    x  = adc_analog_model_i.lvl[ch] >> (12 - n) << (12 - n);
    wr(8'h14, 8'(4 * s + r));
    wr(8'h11, 8'(64 + 16 * d));
    wr(8'h10, 8'(208 + ch));
    rd(8'h10);
    chk("busy", 14'h0000, rv & 14'h0060);
    chk("dac start", 14'h0800, 14'(o_dac));
    wait_irq();
    chk("time", 14'h0001, 14'(t + 2 >= e - dv && t <= e + dv + 4));
    rd(8'h10);
    chk("mode", 14'(176 + ch), rv);
    rd(8'h12);
    chk("high", 14'(x[11:4]), rv);
    chk("sel", 14'h0001 << ch, o_in_sel);
    wr(8'h11, 8'(128 + 16 * d));
    rd(8'h11);
    chk("low", 14'(128 + 16 * d + x[3:0]), rv);
    chk("masked", 14'h0000, 14'(o_irq));
    wr(8'h11, 8'(16 * d));
    rd(8'h11);
    chk("cleared", 14'(16 * d + x[3:0]), rv);
  endtask
  initial begin
    void'($urandom(32'h4779));
    for (int k = 0; k < 14; k++) begin
      adc_analog_model_i.lvl[k] = k == 12 ? 12'h400 : k == 13 ? 12'h000 : 12'($urandom);
    end
    repeat (20) @(posedge i_core_clk);
    i_rst <= 1'b0;
    rd(8'h10);
    chk("mode rst", 14'h0020, rv);
    rd(8'h11);
    chk("flag rst", 14'h0000, rv & 14'h00f0);
    rd(8'h14);
    chk("cfg rst", 14'h000a, rv);
    rd(8'h13);
    chk("unmapped", 14'h0000, rv);
    for (int k = 0; k < 14; k++) conv(k, k % 4, k / 4);
    wr(8'h10, 8'h85);
    rd(8'h10);
    chk("gate off", 14'h0000, o_in_sel);
    chk("power on", 14'h0001, 14'(o_adc_power));
    wr(8'h10, 8'h50);
    rd(8'h10);
    chk("no start", 14'h0030, rv);
    chk("power off", 14'h0000, 14'(o_adc_power));
    wr(8'h11, 8'h40);
    wr(8'h10, 8'hd0);
    wr(8'h10, 8'h00);
    rd(8'h10);
    chk("abort", 14'h0020, rv);
    rd(8'h11);
    chk("no flag", 14'h0040, rv & 14'h00f0);
    wr(8'h22, 8'h01);
    wr(8'h21, 8'h01);
    wr(8'h11, 8'h30);
    chk("irq idle", 14'h0000, 14'(o_irq));
    wr(8'h10, 8'hdc);
    wait_irq();
    rd(8'h20);
    chk("status", 14'h0001, rv);
    rd(8'h11);
    chk("flag", 14'h00b0, rv);
    wr(8'h22, 8'h01);
    rd(8'h20);
    chk("status clr", 14'h0000, rv);
    chk("irq off", 14'h0000, 14'(o_irq));
    final_report();
  end
endmodule // adc_conversion_control_test

// ==== rtl/adc_clk_divider.sv ====
// Converter clock divider: a one-cycle enable pulse every N core cycles.
// Assumes a single core clock; the divide code may change at any time.
`timescale 1ns/1ps
module adc_clk_divider (
  input  wire logic       i_core_clk,
  input  wire logic       i_rst,
  input  wire logic       i_run,
  input  wire logic [1:0] i_div_code,
  output logic            o_tick
);
  logic [4:0] cnt_r;
  logic [4:0] cnt_nxt;
  logic [4:0] div;
  logic       tick_nxt;

  always_comb begin
    unique case (i_div_code)
      2'h0: div = adc_ctrl_pkg::DIV_16;
      2'h1: div = adc_ctrl_pkg::DIV_8;
      2'h2: div = adc_ctrl_pkg::DIV_1;
      2'h3: div = adc_ctrl_pkg::DIV_2;
    endcase
    tick_nxt = 1'b0;
    cnt_nxt  = cnt_r;
    if (!i_run) begin
      cnt_nxt = 5'h00;
    end else if (cnt_r + 5'h01 >= div) begin
      cnt_nxt  = 5'h00;
      tick_nxt = 1'b1;
    end else begin
      cnt_nxt = cnt_r + 5'h01;
    end
  end

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      cnt_r  <= 5'h00;
      o_tick <= 1'b0;
    end else begin
      cnt_r  <= cnt_nxt;
      o_tick <= tick_nxt;
    end
  end
endmodule // adc_clk_divider

// ==== rtl/adc_conversion_control.sv ====
// Register file and sequencer for the successive-approximation converter.
// Assumes a strobe register port, an analog comparator input and one core clock.
// Writes act at the strobe edge; read data stand only in the cycle after the read.
//
// Overview of operation
// - The enable bit powers the converter; at zero it stays off.
// - Writing one to the start bit, with the enable bit also one in the same write, launches one conversion.
// - The start bit is write-only and always reads zero.
// - Done reads one after a conversion; the result registers are then valid.
// - Done reads zero while a conversion is running.
// - Gate zero opens all inputs; gate one connects the selected channel.
// - Codes 0 to 4 pick port A lines 0 to 4; 5 to 11 port B 1 to 7.
// - Code 12 picks a quarter of supply; code 13 picks ground.
// - The end of conversion sets the irq flag; only software clears it.
// - The interrupt request is issued while the irq flag and irq enable are both one, or while the status bit and its enable are both one.
// - Divider code 00, 01, 10, 11 divides core clock by 16, 8, 1, 2.
// - Low four bits of the clock/flag register show result bits 3 to 0.
// - The high result register shows result bits 11 down to 4.
// - Resolution code 00 gives 8 bits, 01 gives 10, 1x gives 12.
// - Sample width code 00, 01, 10, 11 gives 1, 2, 4, 8 converter clocks.
//
// Added by the designer: the plain strobed port.
`timescale 1ns/1ps
module adc_conversion_control (
  input  wire logic        i_core_clk,
  input  wire logic        i_rst,
  input  wire logic [7:0]  i_addr,
  input  wire logic [7:0]  i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  input  wire logic        i_cmp,
  output logic [7:0]       o_rdata,
  output logic             o_adc_power,
  output logic             o_sample,
  output logic [11:0]      o_dac,
  output logic [13:0]      o_in_sel,
  output logic             o_irq
);
  typedef enum logic [1:0] {
    ST_IDLE   = 2'b00,
    ST_SAMPLE = 2'b01,
    ST_CONV   = 2'b10
  } seq_state_e;

  seq_state_e  state_r, state_nxt;
  logic        en_r, en_nxt;
  logic        gate_r, gate_nxt;
  logic [3:0]  chan_r, chan_nxt;
  logic        done_r, done_nxt;
  logic        irqf_r, irqf_nxt;
  logic        irqe_r, irqe_nxt;
  logic [1:0]  div_r, div_nxt;
  logic [1:0]  shw_r, shw_nxt;
  logic [1:0]  resol_r, resol_nxt;
  logic [11:0] result_r, result_nxt;
  logic [11:0] trial_r, trial_nxt;
  logic [3:0]  bit_r, bit_nxt;
  logic [3:0]  scnt_r, scnt_nxt;
  logic        stat_r, stat_nxt;
  logic        sten_r, sten_nxt;
  logic [7:0]  rdata_nxt;
  logic        irq_nxt;
  logic        tick;
  logic        finish;
  logic        wr_mode, wr_flag, wr_cfg, wr_en, wr_clr;

  localparam logic [3:0]  TOP_BIT     = 4'(adc_ctrl_pkg::RES_W - 1);
  localparam logic [11:0] TRIAL_FIRST = 12'h001 << TOP_BIT;

  function automatic logic [3:0] sample_len(input logic [1:0] code);
    sample_len = 4'h1 << code;
  endfunction

  function automatic logic [4:0] res_bits(input logic [1:0] code);
    if (code == adc_ctrl_pkg::RESOL_8) begin
      res_bits = adc_ctrl_pkg::BITS_8;
    end else if (code == adc_ctrl_pkg::RESOL_10) begin
      res_bits = adc_ctrl_pkg::BITS_10;
    end else begin
      res_bits = adc_ctrl_pkg::BITS_12;
    end
  endfunction

  function automatic logic reg_hit(input logic [7:0] addr, input logic [7:0] ofs);
    reg_hit = addr == ofs;
  endfunction

  function automatic logic [3:0] bit_below(input logic [3:0] idx);
    bit_below = idx - 4'h1;
  endfunction

  // The divider only runs during a conversion, so the first tick always lands a
  // full converter period after the start and the sample time is never cut short.
  adc_clk_divider u_div (
    .i_core_clk (i_core_clk),
    .i_rst      (i_rst),
    .i_run      (state_r != ST_IDLE),
    .i_div_code (div_r),
    .o_tick     (tick)
  );

  adc_input_mux u_mux (
    .i_core_clk (i_core_clk),
    .i_rst      (i_rst),
    .i_gate     (gate_r),
    .i_chan     (chan_r),
    .o_sel      (o_in_sel)
  );

  assign wr_mode = i_wr && reg_hit(i_addr, adc_ctrl_pkg::OFS_MODE);
  assign wr_flag = i_wr && reg_hit(i_addr, adc_ctrl_pkg::OFS_CLK_FLAG);
  assign wr_cfg  = i_wr && reg_hit(i_addr, adc_ctrl_pkg::OFS_CFG);
  assign wr_en   = i_wr && reg_hit(i_addr, adc_ctrl_pkg::OFS_IRQ_EN);
  assign wr_clr  = i_wr && reg_hit(i_addr, adc_ctrl_pkg::OFS_IRQ_CLR);

  // Register writes.
  always_comb begin
    en_nxt    = en_r;
    gate_nxt  = gate_r;
    chan_nxt  = chan_r;
    irqe_nxt  = irqe_r;
    div_nxt   = div_r;
    shw_nxt   = shw_r;
    resol_nxt = resol_r;
    sten_nxt  = sten_r;
    if (wr_mode) begin
      en_nxt   = i_wdata[adc_ctrl_pkg::MODE_EN_BIT];
      gate_nxt = i_wdata[adc_ctrl_pkg::MODE_GATE_BIT];
      chan_nxt = i_wdata[3:0];
    end
    if (wr_flag) begin
      irqe_nxt = i_wdata[adc_ctrl_pkg::FLAG_IRQE_BIT];
      div_nxt  = i_wdata[adc_ctrl_pkg::FLAG_DIV_LSB +: 2];
    end
    if (wr_cfg) begin
      shw_nxt   = i_wdata[adc_ctrl_pkg::CFG_SHW_LSB +: 2];
      resol_nxt = i_wdata[1:0];
    end
    if (wr_en) begin
      sten_nxt = i_wdata[adc_ctrl_pkg::STAT_DONE_BIT];
    end
  end

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      en_r    <= adc_ctrl_pkg::MODE_RESET[adc_ctrl_pkg::MODE_EN_BIT];
      gate_r  <= adc_ctrl_pkg::MODE_RESET[adc_ctrl_pkg::MODE_GATE_BIT];
      chan_r  <= adc_ctrl_pkg::MODE_RESET[3:0];
      irqe_r  <= 1'b0;
      div_r   <= 2'h0;
      shw_r   <= adc_ctrl_pkg::SHW_RESET;
      resol_r <= adc_ctrl_pkg::RES_RESET;
      sten_r  <= 1'b0;
    end else begin
      en_r    <= en_nxt;
      gate_r  <= gate_nxt;
      chan_r  <= chan_nxt;
      irqe_r  <= irqe_nxt;
      div_r   <= div_nxt;
      shw_r   <= shw_nxt;
      resol_r <= resol_nxt;
      sten_r  <= sten_nxt;
    end
  end

  // Conversion sequencer: sample for the chosen width, then one bit per tick.
  // The last decided bit is the lowest one kept at the chosen resolution.
  assign finish = state_r == ST_CONV && tick &&
                  bit_r == 4'(adc_ctrl_pkg::RES_W - int'(res_bits(resol_r)));

  always_comb begin
    state_nxt  = state_r;
    scnt_nxt   = scnt_r;
    bit_nxt    = bit_r;
    trial_nxt  = trial_r;
    result_nxt = result_r;
    done_nxt   = done_r;
    unique case (state_r)
      ST_IDLE: begin
        // A start with the converter off is ignored; nothing is powered to run it.
        if (wr_mode && i_wdata[adc_ctrl_pkg::MODE_START_BIT] && en_nxt) begin
          state_nxt = ST_SAMPLE;
          scnt_nxt  = sample_len(shw_r);
          done_nxt  = 1'b0;
          trial_nxt = TRIAL_FIRST;
          bit_nxt   = TOP_BIT;
        end
      end
      ST_SAMPLE: begin
        if (tick) begin
          scnt_nxt = scnt_r - 4'h1;
          if (scnt_r == 4'h1) begin
            state_nxt = ST_CONV;
          end
        end
      end
      ST_CONV: begin
        if (tick) begin
          if (!i_cmp) begin
            trial_nxt[bit_r] = 1'b0;
          end
          if (bit_r != 4'h0) begin
            trial_nxt[bit_below(bit_r)] = 1'b1;
          end
          bit_nxt = bit_below(bit_r);
          if (finish) begin
            state_nxt  = ST_IDLE;
            result_nxt = trial_nxt;
            if (bit_r != 4'h0) begin
              result_nxt[bit_below(bit_r)] = 1'b0;
            end
            done_nxt = 1'b1;
          end
        end
      end
      default: state_nxt = ST_IDLE;
    endcase
    if (!en_nxt) begin
      // Dropping the enable aborts a conversion and leaves the old result valid.
      // The next value is used so that enable and start written together run, and
      // a write that clears the enable stops the sequencer in the same cycle.
      state_nxt = ST_IDLE;
      if (state_r != ST_IDLE) begin
        done_nxt = 1'b1;
      end
    end
  end

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      state_r  <= ST_IDLE;
      scnt_r   <= 4'h0;
      bit_r    <= 4'h0;
      trial_r  <= 12'h000;
      result_r <= 12'h000;
      done_r   <= adc_ctrl_pkg::MODE_RESET[adc_ctrl_pkg::MODE_DONE_BIT];
    end else begin
      state_r  <= state_nxt;
      scnt_r   <= scnt_nxt;
      bit_r    <= bit_nxt;
      trial_r  <= trial_nxt;
      result_r <= result_nxt;
      done_r   <= done_nxt;
    end
  end

  // Flags: a completion in the same cycle as a clear wins over the clear.
  // Software that misses the race still sees the event and is not left waiting.
  always_comb begin
    irqf_nxt = irqf_r;
    stat_nxt = stat_r;
    if (wr_flag && !i_wdata[adc_ctrl_pkg::FLAG_IRQF_BIT]) begin
      irqf_nxt = 1'b0;
    end
    if (wr_clr && i_wdata[adc_ctrl_pkg::STAT_DONE_BIT]) begin
      stat_nxt = 1'b0;
    end
    if (finish) begin
      irqf_nxt = 1'b1;
      stat_nxt = 1'b1;
    end
    // Built from next values so the request rises with the flag, not a cycle later.
    irq_nxt = (irqf_nxt && irqe_nxt) || (stat_nxt && sten_nxt);
  end

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      irqf_r <= 1'b0;
      stat_r <= 1'b0;
      o_irq  <= 1'b0;
    end else begin
      irqf_r <= irqf_nxt;
      stat_r <= stat_nxt;
      o_irq  <= irq_nxt;
    end
  end

  // Read port and analog-side outputs.
  // Read data fall back to zero outside the answer cycle, so a late sample shows.
  always_comb begin
    rdata_nxt = 8'h00;
    if (i_rd) begin
      unique case (i_addr)
        adc_ctrl_pkg::OFS_MODE: rdata_nxt = {en_r, 1'b0, done_r, gate_r, chan_r};
        adc_ctrl_pkg::OFS_CLK_FLAG: rdata_nxt = {irqf_r, irqe_r, div_r, result_r[3:0]};
        adc_ctrl_pkg::OFS_RES_HIGH: rdata_nxt = result_r[11:4];
        adc_ctrl_pkg::OFS_CFG: rdata_nxt = {4'h0, shw_r, resol_r};
        adc_ctrl_pkg::OFS_IRQ_STAT: rdata_nxt = {7'h00, stat_r};
        adc_ctrl_pkg::OFS_IRQ_EN: rdata_nxt = {7'h00, sten_r};
        default: rdata_nxt = 8'h00;
      endcase
    end
  end

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      o_rdata     <= 8'h00;
      o_adc_power <= 1'b0;
      o_sample    <= 1'b0;
      o_dac       <= 12'h000;
    end else begin
      o_rdata     <= rdata_nxt;
      o_adc_power <= en_nxt;
      o_sample    <= state_nxt == ST_SAMPLE;
      o_dac       <= trial_nxt;
    end
  end
endmodule // adc_conversion_control

// ==== rtl/adc_input_mux.sv ====
// Analog input switch control: one-hot select of the converter input source.
// Assumes the analog core treats an all-zero select as every input open.
`timescale 1ns/1ps
module adc_input_mux (
  input  wire logic        i_core_clk,
  input  wire logic        i_rst,
  input  wire logic        i_gate,
  input  wire logic [3:0]  i_chan,
  output logic [13:0]      o_sel
);
  logic [13:0] sel_nxt;

  always_comb begin
    sel_nxt = 14'h0000;
    // Codes above ground are unused and leave every switch open.
    if (i_gate && i_chan <= adc_ctrl_pkg::CHAN_GROUND) begin
      sel_nxt[i_chan] = 1'b1;
    end
  end

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      o_sel <= 14'h0000;
    end else begin
      o_sel <= sel_nxt;
    end
  end
endmodule // adc_input_mux

// ==== shared/adc_ctrl_pkg.sv ====
// Package of register offsets, field positions, reset values and codes for the converter control.
// Assumes byte-wide registers on a plain strobe port with an 8-bit address.
package adc_ctrl_pkg;
  localparam int         ADDR_W         = 8;
  localparam int         DATA_W         = 8;
  localparam int         RES_W          = 12;
  localparam logic [7:0] OFS_MODE       = 8'h10;
  localparam logic [7:0] OFS_CLK_FLAG   = 8'h11;
  localparam logic [7:0] OFS_RES_HIGH   = 8'h12;
  localparam logic [7:0] OFS_CFG        = 8'h14;
  localparam logic [7:0] OFS_IRQ_STAT   = 8'h20;
  localparam logic [7:0] OFS_IRQ_EN     = 8'h21;
  localparam logic [7:0] OFS_IRQ_CLR    = 8'h22;
  localparam int         MODE_EN_BIT    = 7;
  localparam int         MODE_START_BIT = 6;
  localparam int         MODE_DONE_BIT  = 5;
  localparam int         MODE_GATE_BIT  = 4;
  localparam int         FLAG_IRQF_BIT  = 7;
  localparam int         FLAG_IRQE_BIT  = 6;
  localparam int         FLAG_DIV_LSB   = 4;
  localparam int         CFG_SHW_LSB    = 2;
  localparam int         STAT_DONE_BIT  = 0;
  localparam logic [7:0] MODE_RESET     = 8'h20;
  localparam logic [1:0] SHW_RESET      = 2'h2;
  localparam logic [1:0] RES_RESET      = 2'h2;
  localparam logic [3:0] CHAN_QUARTER   = 4'hc;
  localparam logic [3:0] CHAN_GROUND    = 4'hd;
  localparam logic [3:0] CHAN_PB_FIRST  = 4'h5;
  localparam logic [3:0] CHAN_PB_LAST   = 4'hb;
  localparam logic [1:0] RESOL_8        = 2'h0;
  localparam logic [1:0] RESOL_10       = 2'h1;
  localparam logic [4:0] BITS_8         = 5'h08;
  localparam logic [4:0] BITS_10        = 5'h0a;
  localparam logic [4:0] BITS_12        = 5'h0c;
  localparam logic [4:0] DIV_16         = 5'h10;
  localparam logic [4:0] DIV_8          = 5'h08;
  localparam logic [4:0] DIV_1          = 5'h01;
  localparam logic [4:0] DIV_2          = 5'h02;
  localparam int         SEL_W          = 14;
endpackage
